/* File: verilog/uwk_defines.svh */
`ifndef UWK_DEFINES_SVH
`define UWK_DEFINES_SVH
// register byte offsets
`define UWK_CTRL_OFS 8'h40
`define UWK_FLAGS_OFS 8'h44
`define UWK_COMP_OFS 8'h48
`define UWK_IRQ_EN_OFS 8'h4c
`define UWK_IRQ_CLR_OFS 8'h50
`define UWK_IRQ_STAT_OFS 8'h54
// wake source bit positions, shared by control and flag registers
`define UWK_BIT_CTS 0
`define UWK_BIT_DATA 1
`define UWK_BIT_THR 2
`define UWK_BIT_ADDR 3
`define UWK_BIT_TOUT 4
`define UWK_NSRC 5
`define UWK_COMP_W 16
// reset values
`define UWK_CTRL_RST 5'h00
`define UWK_FLAGS_RST 5'h00
`define UWK_COMP_RST 16'h0000
`define UWK_ADDR_W 8
`endif

/* File: verilog/uwk_pkg.sv */
package uwk_pkg;
   typedef enum logic [1:0] {
      UWK_IDLE,
      UWK_COMP,
      UWK_GO
   } uwk_phase_t;

   typedef struct packed {
      logic [4:0] wake_en;
      logic [4:0] flags;
      logic [15:0] comp;
      logic [2:0] irq_en;
      logic [2:0] irq_stat;
      logic ack;
      logic [31:0] rdata;
      uwk_phase_t phase;
      logic [15:0] cnt;
      logic start_take;
      logic pd_prev;
   } uwk_state_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } uwk_wb_req_t;
endpackage

/* File: verilog/uwk_wake_status.sv */
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "uwk_defines.svh"
module uwk_wake_status (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire uwk_pkg::uwk_wb_req_t wb_req_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic power_down_in,
   input wire logic [4:0] wake_event_in,
   output logic wake_out,
   output logic start_bit_take_out,
   output logic comp_busy_out,
   output logic irq_out
);
   uwk_pkg::uwk_state_t s_q;
   uwk_pkg::uwk_state_t s_d;
   logic [4:0] wake_hit;
   logic acc;
   logic wr;
   logic [4:0] clr_mask;
   logic [2:0] irq_ev;
   logic [31:0] rd_mux;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // a source counts only while powered down and enabled
   genvar g;
   generate
      for (g = 0; g < `UWK_NSRC; g++) begin : g_src
         assign wake_hit[g] = power_down_in & s_q.wake_en[g] & wake_event_in[g];
      end
   endgenerate

   assign acc = wb_req_in.cyc & wb_req_in.stb & ~s_q.ack;
   assign wr = acc & wb_req_in.we & wb_req_in.sel[0];
   assign clr_mask = (wr && hit(wb_req_in.adr, `UWK_FLAGS_OFS)) ? wb_req_in.dat[4:0] : 5'h00;
   // events: any wake, start bit taken, compensation started
   // taken from state, not from s_d, so the next-state logic has no loop through irq_ev
   assign irq_ev[2] = (s_q.phase == uwk_pkg::UWK_IDLE) & wake_hit[`UWK_BIT_DATA]
                      & s_q.wake_en[`UWK_BIT_DATA];
   assign irq_ev[1] = (s_q.phase == uwk_pkg::UWK_GO);
   assign irq_ev[0] = |wake_hit;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (wb_req_in.adr)
         `UWK_CTRL_OFS: begin
            rd_mux = {27'h0, s_q.wake_en};
         end
         `UWK_FLAGS_OFS: begin
            rd_mux = {27'h0, s_q.flags};
         end
         `UWK_COMP_OFS: begin
            rd_mux = {16'h0, s_q.comp};
         end
         `UWK_IRQ_EN_OFS: begin
            rd_mux = {29'h0, s_q.irq_en};
         end
         `UWK_IRQ_STAT_OFS: begin
            rd_mux = {29'h0, s_q.irq_stat};
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.ack = acc;
      s_d.start_take = 1'b0;
      s_d.pd_prev = power_down_in;
      if (acc && !wb_req_in.we) begin
         s_d.rdata = rd_mux;
      end
      if (wr) begin
         if (hit(wb_req_in.adr, `UWK_CTRL_OFS)) begin
            s_d.wake_en = wb_req_in.dat[4:0];
         end
         if (hit(wb_req_in.adr, `UWK_COMP_OFS)) begin
            s_d.comp[7:0] = wb_req_in.dat[7:0];
         end
         if (hit(wb_req_in.adr, `UWK_IRQ_EN_OFS)) begin
            s_d.irq_en = wb_req_in.dat[2:0];
         end
      end
      if (acc && wb_req_in.we && wb_req_in.sel[1] && hit(wb_req_in.adr, `UWK_COMP_OFS)) begin
         s_d.comp[15:8] = wb_req_in.dat[15:8];
      end
      // set beats clear; zero bits in the write leave flags untouched
      s_d.flags = (s_q.flags & ~clr_mask) | wake_hit;
      case (s_q.phase)
         uwk_pkg::UWK_IDLE: begin
            if (wake_hit[`UWK_BIT_DATA]) begin
               // only reached when data wake is enabled
               if (s_q.comp == `UWK_COMP_RST) begin
                  s_d.phase = uwk_pkg::UWK_GO;
               end else begin
                  s_d.phase = uwk_pkg::UWK_COMP;
                  s_d.cnt = s_q.comp;
               end
            end
         end
         uwk_pkg::UWK_COMP: begin
            if (s_q.cnt == 16'h0001) begin
               s_d.phase = uwk_pkg::UWK_GO;
            end
            s_d.cnt = s_q.cnt - 16'h0001;
         end
         uwk_pkg::UWK_GO: begin
            s_d.start_take = 1'b1;
            s_d.phase = uwk_pkg::UWK_IDLE;
         end
         default: s_d.phase = uwk_pkg::UWK_IDLE;
      endcase
      s_d.irq_stat = s_q.irq_stat & ~((wr && hit(wb_req_in.adr, `UWK_IRQ_CLR_OFS))
                                      ? wb_req_in.dat[2:0] : 3'h0);
      s_d.irq_stat = s_d.irq_stat | irq_ev;
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         s_q <= '{wake_en: `UWK_CTRL_RST,
                  flags: `UWK_FLAGS_RST,
                  comp: `UWK_COMP_RST,
                  irq_en: 3'h0,
                  irq_stat: 3'h0,
                  ack: 1'b0,
                  rdata: 32'h0000_0000,
                  phase: uwk_pkg::UWK_IDLE,
                  cnt: 16'h0000,
                  start_take: 1'b0,
                  pd_prev: 1'b0};
      end else if (clk_en_in) begin
         s_q <= s_d;
      end
   end

   assign wb_dat_out = s_q.rdata;
   assign wb_ack_out = s_q.ack;
   assign wake_out = |wake_hit;
   assign start_bit_take_out = s_q.start_take;
   assign comp_busy_out = s_q.phase != uwk_pkg::UWK_IDLE;
   assign irq_out = |(s_q.irq_stat & s_q.irq_en);

   // assertions
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   a_tout_flag_set: assert property (clk_en_in && wake_hit[4] |=> s_q.flags[4])
      else $error("time-out wake flag not set");
   a_addr_flag_set: assert property (clk_en_in && wake_hit[3] |=> s_q.flags[3])
      else $error("address wake flag not set");
   a_thr_flag_set: assert property (clk_en_in && wake_hit[2] |=> s_q.flags[2])
      else $error("threshold wake flag not set");
   a_data_flag_set: assert property (clk_en_in && wake_hit[1] |=> s_q.flags[1])
      else $error("data wake flag not set");
   a_cts_flag_set: assert property (clk_en_in && wake_hit[0] |=> s_q.flags[0])
      else $error("cts wake flag not set");
   a_flag_no_cause: assert property (clk_en_in && !$past(s_q.flags[0]) && !s_q.flags[0] && !wake_hit[0]
                                     |=> !s_q.flags[0])
      else $error("cts flag rose without a wake");
   a_flag_w1c: assert property (clk_en_in && clr_mask[2] && !wake_hit[2] |=> !s_q.flags[2])
      else $error("flag not cleared by write one");
   a_flag_sticky: assert property (clk_en_in && s_q.flags[3] && !clr_mask[3] |=> s_q.flags[3])
      else $error("flag dropped without clear");
   a_res_bits_zero: assert property (s_q.ack && $past(wb_req_in.adr) == `UWK_COMP_OFS
                                     |-> wb_dat_out[31:16] == 16'h0000)
      else $error("reserved compensation bits not zero");
   a_no_en_no_wake: assert property (!s_q.wake_en[4] |-> !wake_hit[4])
      else $error("disabled source woke the chip");
   a_comp_wait: assert property (clk_en_in && s_q.phase == uwk_pkg::UWK_COMP && s_q.cnt == 16'h0002
                                 ##1 clk_en_in |=> s_q.phase == uwk_pkg::UWK_GO)
      else $error("compensation count off");
   a_comp_gated: assert property (clk_en_in && s_q.phase == uwk_pkg::UWK_IDLE && !s_q.wake_en[1]
                                  |=> s_q.phase == uwk_pkg::UWK_IDLE)
      else $error("compensation ran with data wake off");

   a_cts_flag_zero: assert property (clk_en_in && !s_q.flags[0] && !wake_hit[0] |=> !s_q.flags[0])
      else $error("cts flag set without a wake");
   a_data_flag_zero: assert property (clk_en_in && !s_q.flags[1] && !wake_hit[1] |=> !s_q.flags[1])
      else $error("data flag set without a wake");
   a_thr_flag_zero: assert property (clk_en_in && !s_q.flags[2] && !wake_hit[2] |=> !s_q.flags[2])
      else $error("threshold flag set without a wake");
   a_addr_flag_zero: assert property (clk_en_in && !s_q.flags[3] && !wake_hit[3] |=> !s_q.flags[3])
      else $error("address flag set without a wake");
   a_tout_flag_zero: assert property (clk_en_in && !s_q.flags[4] && !wake_hit[4] |=> !s_q.flags[4])
      else $error("time-out flag set without a wake");
   a_cts_flag_clr: assert property (clk_en_in && clr_mask[0] && !wake_hit[0] |=> !s_q.flags[0])
      else $error("cts flag not cleared");
   a_data_flag_clr: assert property (clk_en_in && clr_mask[1] && !wake_hit[1] |=> !s_q.flags[1])
      else $error("data flag not cleared");
   a_addr_flag_clr: assert property (clk_en_in && clr_mask[3] && !wake_hit[3] |=> !s_q.flags[3])
      else $error("address flag not cleared");
   a_tout_flag_clr: assert property (clk_en_in && clr_mask[4] && !wake_hit[4] |=> !s_q.flags[4])
      else $error("time-out flag not cleared");
   a_cts_flag_hold: assert property (clk_en_in && s_q.flags[0] && !clr_mask[0] |=> s_q.flags[0])
      else $error("cts flag dropped without clear");
   a_data_flag_hold: assert property (clk_en_in && s_q.flags[1] && !clr_mask[1] |=> s_q.flags[1])
      else $error("data flag dropped without clear");
   a_thr_flag_hold: assert property (clk_en_in && s_q.flags[2] && !clr_mask[2] |=> s_q.flags[2])
      else $error("threshold flag dropped without clear");
   a_tout_flag_hold: assert property (clk_en_in && s_q.flags[4] && !clr_mask[4] |=> s_q.flags[4])
      else $error("time-out flag dropped without clear");
   a_cts_need_en: assert property (!s_q.wake_en[0] |-> !wake_hit[0])
      else $error("disabled cts source woke the chip");
   a_data_need_en: assert property (!s_q.wake_en[1] |-> !wake_hit[1])
      else $error("disabled data source woke the chip");
   a_thr_need_en: assert property (!s_q.wake_en[2] |-> !wake_hit[2])
      else $error("disabled threshold source woke the chip");
   a_addr_need_en: assert property (!s_q.wake_en[3] |-> !wake_hit[3])
      else $error("disabled address source woke the chip");
   a_cts_need_pd: assert property (!power_down_in |-> !wake_hit[0])
      else $error("cts wake outside power-down");
   a_data_need_pd: assert property (!power_down_in |-> !wake_hit[1])
      else $error("data wake outside power-down");
   a_thr_need_pd: assert property (!power_down_in |-> !wake_hit[2])
      else $error("threshold wake outside power-down");
   a_addr_need_pd: assert property (!power_down_in |-> !wake_hit[3])
      else $error("address wake outside power-down");
   a_tout_need_pd: assert property (!power_down_in |-> !wake_hit[4])
      else $error("time-out wake outside power-down");
   a_cts_no_event: assert property (!wake_event_in[0] |-> !wake_hit[0])
      else $error("cts wake without an event");
   a_data_no_event: assert property (!wake_event_in[1] |-> !wake_hit[1])
      else $error("data wake without an event");
   a_thr_no_event: assert property (!wake_event_in[2] |-> !wake_hit[2])
      else $error("threshold wake without an event");
   a_addr_no_event: assert property (!wake_event_in[3] |-> !wake_hit[3])
      else $error("address wake without an event");
   a_tout_no_event: assert property (!wake_event_in[4] |-> !wake_hit[4])
      else $error("time-out wake without an event");
   a_cts_set_wins: assert property (clk_en_in && clr_mask[0] && wake_hit[0] |=> s_q.flags[0])
      else $error("cts clear beat a wake");
   a_data_set_wins: assert property (clk_en_in && clr_mask[1] && wake_hit[1] |=> s_q.flags[1])
      else $error("data clear beat a wake");
   a_thr_set_wins: assert property (clk_en_in && clr_mask[2] && wake_hit[2] |=> s_q.flags[2])
      else $error("threshold clear beat a wake");
   a_addr_set_wins: assert property (clk_en_in && clr_mask[3] && wake_hit[3] |=> s_q.flags[3])
      else $error("address clear beat a wake");
   a_tout_set_wins: assert property (clk_en_in && clr_mask[4] && wake_hit[4] |=> s_q.flags[4])
      else $error("time-out clear beat a wake");
   a_cts_flag_frozen: assert property (!clk_en_in |=> $stable(s_q.flags[0]))
      else $error("cts flag moved while frozen");
   a_data_flag_frozen: assert property (!clk_en_in |=> $stable(s_q.flags[1]))
      else $error("data flag moved while frozen");
   a_thr_flag_frozen: assert property (!clk_en_in |=> $stable(s_q.flags[2]))
      else $error("threshold flag moved while frozen");
   a_addr_flag_frozen: assert property (!clk_en_in |=> $stable(s_q.flags[3]))
      else $error("address flag moved while frozen");
   a_tout_flag_frozen: assert property (!clk_en_in |=> $stable(s_q.flags[4]))
      else $error("time-out flag moved while frozen");
   a_cts_wake_out: assert property (wake_hit[0] |-> wake_out)
      else $error("cts wake not shown");
   a_data_wake_out: assert property (wake_hit[1] |-> wake_out)
      else $error("data wake not shown");
   a_thr_wake_out: assert property (wake_hit[2] |-> wake_out)
      else $error("threshold wake not shown");
   a_addr_wake_out: assert property (wake_hit[3] |-> wake_out)
      else $error("address wake not shown");
   a_tout_wake_out: assert property (wake_hit[4] |-> wake_out)
      else $error("time-out wake not shown");
   a_cts_irq_ev: assert property (clk_en_in && wake_hit[0] |=> s_q.irq_stat[0])
      else $error("cts wake raised no event");
   a_data_irq_ev: assert property (clk_en_in && wake_hit[1] |=> s_q.irq_stat[0])
      else $error("data wake raised no event");
   a_thr_irq_ev: assert property (clk_en_in && wake_hit[2] |=> s_q.irq_stat[0])
      else $error("threshold wake raised no event");
   a_addr_irq_ev: assert property (clk_en_in && wake_hit[3] |=> s_q.irq_stat[0])
      else $error("address wake raised no event");
   a_tout_irq_ev: assert property (clk_en_in && wake_hit[4] |=> s_q.irq_stat[0])
      else $error("time-out wake raised no event");
   a_cts_flag_read: assert property (clk_en_in && acc && !wb_req_in.we
                                     && hit(wb_req_in.adr, `UWK_FLAGS_OFS)
                                     |=> wb_dat_out[0] == $past(s_q.flags[0]))
      else $error("cts flag read wrong");
   a_data_flag_read: assert property (clk_en_in && acc && !wb_req_in.we
                                      && hit(wb_req_in.adr, `UWK_FLAGS_OFS)
                                      |=> wb_dat_out[1] == $past(s_q.flags[1]))
      else $error("data flag read wrong");
   a_thr_flag_read: assert property (clk_en_in && acc && !wb_req_in.we
                                     && hit(wb_req_in.adr, `UWK_FLAGS_OFS)
                                     |=> wb_dat_out[2] == $past(s_q.flags[2]))
      else $error("threshold flag read wrong");
   a_addr_flag_read: assert property (clk_en_in && acc && !wb_req_in.we
                                      && hit(wb_req_in.adr, `UWK_FLAGS_OFS)
                                      |=> wb_dat_out[3] == $past(s_q.flags[3]))
      else $error("address flag read wrong");
   a_tout_flag_read: assert property (clk_en_in && acc && !wb_req_in.we
                                      && hit(wb_req_in.adr, `UWK_FLAGS_OFS)
                                      |=> wb_dat_out[4] == $past(s_q.flags[4]))
      else $error("time-out flag read wrong");
   a_flags_res_zero: assert property (clk_en_in && acc && !wb_req_in.we
                                      && hit(wb_req_in.adr, `UWK_FLAGS_OFS)
                                      |=> wb_dat_out[31:5] == 27'h0)
      else $error("reserved flag bits not zero");
   a_ack_answer: assert property (clk_en_in && acc |=> wb_ack_out)
      else $error("access not acknowledged");
   a_ack_one_cycle: assert property (clk_en_in && wb_ack_out |=> !wb_ack_out)
      else $error("ack held too long");
   a_take_pulse: assert property (clk_en_in && start_bit_take_out |=> !start_bit_take_out)
      else $error("take pulse too long");
   a_go_takes: assert property (clk_en_in && s_q.phase == uwk_pkg::UWK_GO |=> start_bit_take_out)
      else $error("take pulse missing");
   a_take_only_go: assert property (clk_en_in && !start_bit_take_out
                                    && s_q.phase != uwk_pkg::UWK_GO |=> !start_bit_take_out)
      else $error("take pulse without go");
   a_comp_zero_go: assert property (clk_en_in && s_q.phase == uwk_pkg::UWK_IDLE && wake_hit[1]
                                    && s_q.comp == 16'h0000 |=> s_q.phase == uwk_pkg::UWK_GO)
      else $error("zero compensation did not go");
   a_comp_load: assert property (clk_en_in && s_q.phase == uwk_pkg::UWK_IDLE && wake_hit[1]
                                 && s_q.comp != 16'h0000
                                 |=> s_q.phase == uwk_pkg::UWK_COMP && s_q.cnt == $past(s_q.comp))
      else $error("compensation not loaded");
   a_cnt_moves: assert property (clk_en_in && s_q.phase == uwk_pkg::UWK_COMP
                                 |=> s_q.cnt == $past(s_q.cnt) - 16'h0001)
      else $error("compensation count stalled");
   a_ctrl_write: assert property (clk_en_in && wr && hit(wb_req_in.adr, `UWK_CTRL_OFS)
                                  |=> s_q.wake_en == $past(wb_req_in.dat[4:0]))
      else $error("wake enable write lost");
   a_irq_clear: assert property (clk_en_in && wr && hit(wb_req_in.adr, `UWK_IRQ_CLR_OFS)
                                 && wb_req_in.dat[0] && !(|wake_hit) |=> !s_q.irq_stat[0])
      else $error("irq status not cleared");
   a_irq_off_en: assert property (s_q.irq_en == 3'h0 |-> !irq_out)
      else $error("irq without enable");
   a_no_pd_no_wake: assert property (!power_down_in |-> !wake_out)
      else $error("wake outside power-down");

   c_data_wake: cover property (wake_hit[1] ##[1:40] start_bit_take_out);
   c_comp_run: cover property (s_q.phase == uwk_pkg::UWK_COMP ##1 s_q.phase == uwk_pkg::UWK_GO);
   c_clear_flag: cover property (s_q.flags[0] ##1 clr_mask[0]);
   c_irq: cover property (irq_out);
   c_set_and_clear: cover property (clr_mask[2] && wake_hit[2]);
endmodule // uwk_wake_status

/* File: sim/uwk_partner.sv */
`timescale 1ns/1ps
module uwk_partner (
   input wire logic clock_in,
   output logic [4:0] wake_event_out
);
   initial wake_event_out = 5'h00;
   // remote side gives one-cycle events only, never a held level
   task automatic fire(input int idx);
      @(posedge clock_in);
      wake_event_out <= 5'h01 << idx;
      @(posedge clock_in);
      wake_event_out <= 5'h00;
   endtask
endmodule // uwk_partner

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "uwk_defines.svh"
module tb_top;
   logic clock_in = 0;
   logic sys_rst_in = 1;
   logic pd = 0;
   uwk_pkg::uwk_wb_req_t req = '0;
   logic [31:0] rdat, q, seed = 32'h4df311cc;
   logic ack, take, irq, wk, busy;
   logic [4:0] ev, flags_m = 5'h00;
   int n_errors = 0, n_tests = 0, cnt, n_comp;
   uwk_wake_status DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
      .wb_req_in(req), .wb_dat_out(rdat), .wb_ack_out(ack), .power_down_in(pd),
      .wake_event_in(ev), .wake_out(wk), .start_bit_take_out(take), .comp_busy_out(busy),
      .irq_out(irq));
   uwk_partner p (.clock_in(clock_in), .wake_event_out(ev));
   initial forever #4 clock_in = ~clock_in;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      req <= '{1'b1, 1'b1, we, 4'hf, a, d};
      do begin
         @(posedge clock_in);
         t++;
      end while (ack !== 1'b1 && t < 50);
      q = rdat;
      if (t >= 50) n_errors++;
      req <= '0;
      @(posedge clock_in);
   endtask
   task automatic complete_run();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #400000;
      n_errors++;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge clock_in);
      sys_rst_in <= 0;
      @(posedge clock_in);
      wb(0, `UWK_FLAGS_OFS, 0); chk("flags_rst", q, 0);
      wb(0, `UWK_COMP_OFS, 0); chk("comp_rst", q, 0);
      wb(1, `UWK_COMP_OFS, xs());
      wb(0, `UWK_COMP_OFS, 0); chk("comp_rw", q, {16'h0, seed[15:0]});
      wb(0, 8'hfc, 0); chk("unmapped", q, 0);
      n_comp = int'(xs() & 32'hf) + 1;
      wb(1, `UWK_COMP_OFS, n_comp);
      wb(1, `UWK_IRQ_EN_OFS, 32'h7);
      pd <= 1;
      for (int i = 0; i < 5; i++) begin
         wb(1, `UWK_CTRL_OFS, 0);
         p.fire(i);
         chk("wake_off", wk, 0);
         wb(0, `UWK_FLAGS_OFS, 0); chk("flag_off", q, flags_m);
         wb(1, `UWK_CTRL_OFS, 32'h1f);
         p.fire(i);
         chk("wake_on", wk, 1);
         flags_m[i] = 1'b1;
         cnt = 0;
         // short count keeps the take pulse inside this window
         while (i == 1 && take !== 1'b1 && cnt < 40) begin
            @(posedge clock_in);
            cnt++;
            if (cnt == 1) chk("comp_busy", busy, 1);
         end
         if (i == 1) chk("comp_wait", cnt >= n_comp && cnt <= n_comp + 4, 1);
         wb(0, `UWK_FLAGS_OFS, 0); chk("flag_on", q, flags_m);
         chk("irq_on", irq, 1);
         wb(1, `UWK_FLAGS_OFS, 0);
         wb(0, `UWK_FLAGS_OFS, 0); chk("flag_hold", q, flags_m);
         wb(1, `UWK_FLAGS_OFS, 32'h1 << i);
         flags_m[i] = 1'b0;
         wb(0, `UWK_FLAGS_OFS, 0); chk("flag_clr", q, flags_m);
      end
      wb(1, `UWK_IRQ_CLR_OFS, 32'h7);
      chk("irq_clr", irq, 0);
      wb(1, `UWK_CTRL_OFS, 32'h1d);
      p.fire(1);
      cnt = 0;
      repeat (30) begin
         @(posedge clock_in);
         if (take === 1'b1) cnt++;
      end
      chk("comp_off", cnt, 0);
      complete_run();
   end
endmodule // tb_top
